// ==== rtl/status_lamp_pkg.sv ====
// Purpose: constants and carrier types for the front-panel lamp controller
// Assumes: 40 MHz clock, synchronous active-high reset standing for power-on
// Notes:
// Operation
// - ports with no antenna sensed at power-on stay disabled until the next power-on
// - running lamp goes steady on when self-test completes, about five seconds
// - short flash: 500 ms period, 250 ms on then 250 ms off
// - long flash: 3000 ms period, 1500 ms on then 1500 ms off
// - halting system error holds red error lamp on with running lamp off
// - settings error flashes error lamp with short pattern
// - waiting for network flashes error lamp with long pattern
// - normal completion lights green result lamp 50 ms, cut by failure lamp
// - abnormal completion lights red failure lamp 50 ms, cut by success lamp
// - each enabled port lamp lit while communication runs through that port, once self-test completes
// - antenna sensed after power-on gives that port lamp one 50 ms pulse
// - each input lamp lit exactly while its digital input is active
// - each output lamp lit exactly while its digital output is driven active
package status_lamp_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TICK_US         = 1000;
  // one millisecond enable tick
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned SHORT_HALF_MS   = 250;
  localparam int unsigned LONG_HALF_MS    = 1500;
  localparam int unsigned RESULT_MS       = 50;
  localparam int unsigned PULSE_MS        = 50;
  localparam int unsigned SELFTEST_MS     = 5000;
  localparam int unsigned NUM_PORTS       = 4;
  localparam logic [15:0] TICK_RESET      = 16'h0000;
  localparam logic [12:0] MS_RESET        = 13'h0000;

  typedef enum logic [1:0]
  {
    RUN_SELFTEST = 2'b00,
    RUN_READY    = 2'b01
  } run_state_t;

  typedef struct packed
  {
    logic       booting;
    logic       safeMode;
    logic       sysError;
    logic       setError;
    logic       netWait;
    logic       cmdOk;
    logic       cmdFail;
  } sys_status_t;

  typedef struct packed
  {
    logic [3:0] portSense;
    logic [3:0] portBusy;
    logic [3:0] digIn;
    logic [3:0] digOut;
  } port_status_t;

  typedef struct packed
  {
    logic       supplyIndicator;
    logic       runIndicator;
    logic       errorIndicator;
    logic       normalIndicator;
    logic       failureIndicator;
    logic [3:0] portActivityIndicator;
    logic [3:0] inputIndicator;
    logic [3:0] outputIndicator;
  } lamps_t;

endpackage

// ==== rtl/reader_status_led_control.sv ====
// Purpose: drives reader front-panel lamps and antenna port enables
// Assumes: status inputs come from the reader controller on the same clock, except
//          antenna sense and digital levels, which are pins and are synchronised
// Notes: reset is treated as power-on; port enables are frozen at the end of self-test
`timescale 1ns/100ps

module reader_status_led_control
  import status_lamp_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // controller state
  input  wire sys_status_t  sysStatus,
  input  wire logic [3:0]   portBusy,
  // pins
  input  wire logic [3:0]   portSense,
  input  wire logic [3:0]   digIn,
  input  wire logic [3:0]   digOut,
  // lamps and port enables
  output lamps_t            lamps,
  output logic [3:0]        portEnable,
  output logic              ready
);

  function automatic logic [12:0] countDown(input logic [12:0] v, input logic tick);
    countDown = (tick && v != 13'h0000) ? v - 13'h0001 : v;
  endfunction

  // pin synchronisers
  logic [3:0] senseS1_q, senseS2_q, inS1_q, inS2_q, outS1_q, outS2_q;
  always_ff @(posedge clock)
  begin
    senseS1_q <= portSense;
    senseS2_q <= senseS1_q;
    inS1_q    <= digIn;
    inS2_q    <= inS1_q;
    outS1_q   <= digOut;
    outS2_q   <= outS1_q;
  end

  // millisecond tick and flash generators
  logic [15:0] tick_q, tick_d;
  logic        msTick_q, msTick_d;
  logic [12:0] shortCnt_q, shortCnt_d, longCnt_q, longCnt_d;
  logic        shortPh_q, shortPh_d, longPh_q, longPh_d;

  always_comb
  begin
    tick_d     = tick_q + 16'h0001;
    msTick_d   = 1'b0;
    shortCnt_d = shortCnt_q;
    longCnt_d  = longCnt_q;
    shortPh_d  = shortPh_q;
    longPh_d   = longPh_q;
    if (tick_q == 16'(TICK_CYCLES - 1))
    begin
      tick_d   = TICK_RESET;
      msTick_d = 1'b1;
    end
    if (msTick_q)
    begin
      if (shortCnt_q == 13'(SHORT_HALF_MS - 1))
      begin
        shortCnt_d = MS_RESET;
        shortPh_d  = ~shortPh_q;
      end
      else
        shortCnt_d = shortCnt_q + 13'h0001;
      if (longCnt_q == 13'(LONG_HALF_MS - 1))
      begin
        longCnt_d = MS_RESET;
        longPh_d  = ~longPh_q;
      end
      else
        longCnt_d = longCnt_q + 13'h0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tick_q     <= TICK_RESET;
      msTick_q   <= 1'b0;
      shortCnt_q <= MS_RESET;
      longCnt_q  <= MS_RESET;
      shortPh_q  <= 1'b1;
      longPh_q   <= 1'b1;
    end
    else
    begin
      tick_q     <= tick_d;
      msTick_q   <= msTick_d;
      shortCnt_q <= shortCnt_d;
      longCnt_q  <= longCnt_d;
      shortPh_q  <= shortPh_d;
      longPh_q   <= longPh_d;
    end
  end

  // self-test, port enables and sense pulses
  run_state_t  run_q, run_d;
  logic [12:0] testCnt_q, testCnt_d;
  logic [3:0]  enable_q, enable_d, senseOld_q, senseOld_d;
  logic [12:0] pulseCnt_q [NUM_PORTS];
  logic [12:0] pulseCnt_d [NUM_PORTS];

  always_comb
  begin
    run_d      = run_q;
    testCnt_d  = testCnt_q;
    enable_d   = enable_q;
    senseOld_d = senseS2_q;
    for (int i = 0; i < NUM_PORTS; i++)
      pulseCnt_d[i] = countDown(pulseCnt_q[i], msTick_q);
    unique case (run_q)
      RUN_SELFTEST:
      begin
        testCnt_d = countDown(testCnt_q, msTick_q);
        enable_d  = senseS2_q;
        if (testCnt_q == 13'h0000)
          run_d = RUN_READY;
      end
      RUN_READY:
      begin
        for (int i = 0; i < NUM_PORTS; i++)
          if (senseS2_q[i] && !senseOld_q[i])
            pulseCnt_d[i] = 13'(PULSE_MS);
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      run_q      <= RUN_SELFTEST;
      testCnt_q  <= 13'(SELFTEST_MS);
      enable_q   <= 4'h0;
      senseOld_q <= 4'h0;
      for (int i = 0; i < NUM_PORTS; i++)
        pulseCnt_q[i] <= MS_RESET;
    end
    else
    begin
      run_q      <= run_d;
      testCnt_q  <= testCnt_d;
      enable_q   <= enable_d;
      senseOld_q <= senseOld_d;
      for (int i = 0; i < NUM_PORTS; i++)
        pulseCnt_q[i] <= pulseCnt_d[i];
    end
  end

  // communication result lamps
  logic [12:0] okCnt_q, okCnt_d, failCnt_q, failCnt_d;

  always_comb
  begin
    okCnt_d   = countDown(okCnt_q, msTick_q);
    failCnt_d = countDown(failCnt_q, msTick_q);
    // the newer result wins; a fresh result cuts the other lamp short
    if (sysStatus.cmdFail)
    begin
      failCnt_d = 13'(RESULT_MS);
      okCnt_d   = MS_RESET;
    end
    else if (sysStatus.cmdOk)
    begin
      okCnt_d   = 13'(RESULT_MS);
      failCnt_d = MS_RESET;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      okCnt_q   <= MS_RESET;
      failCnt_q <= MS_RESET;
    end
    else
    begin
      okCnt_q   <= okCnt_d;
      failCnt_q <= failCnt_d;
    end
  end

  // lamp outputs, all registered
  lamps_t lamps_d;
  logic [3:0] pulseOn;
  logic [3:0] liveEnable;

  always_comb
  begin
    // no port counts as enabled until self-test has frozen the enables
    liveEnable = (run_q == RUN_READY) ? enable_q : 4'h0;
    for (int i = 0; i < NUM_PORTS; i++)
      pulseOn[i] = pulseCnt_q[i] != 13'h0000;
    lamps_d.supplyIndicator = 1'b1;
    if (sysStatus.sysError)
      lamps_d.runIndicator = 1'b0;
    else if (sysStatus.booting || run_q == RUN_SELFTEST)
      lamps_d.runIndicator = shortPh_q;
    else if (sysStatus.safeMode)
      lamps_d.runIndicator = longPh_q;
    else
      lamps_d.runIndicator = 1'b1;
    if (sysStatus.sysError)
      lamps_d.errorIndicator = 1'b1;
    else if (sysStatus.setError)
      lamps_d.errorIndicator = shortPh_q;
    else if (sysStatus.netWait)
      lamps_d.errorIndicator = longPh_q;
    else
      lamps_d.errorIndicator = 1'b0;
    lamps_d.normalIndicator       = okCnt_q != 13'h0000;
    lamps_d.failureIndicator      = failCnt_q != 13'h0000;
    lamps_d.portActivityIndicator = (portBusy & liveEnable) | pulseOn;
    lamps_d.inputIndicator        = inS2_q;
    lamps_d.outputIndicator       = outS2_q;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lamps      <= '0;
      portEnable <= 4'h0;
      ready      <= 1'b0;
    end
    else
    begin
      lamps      <= lamps_d;
      portEnable <= (run_q == RUN_READY) ? enable_q : 4'h0;
      ready      <= run_q == RUN_READY;
    end
  end

endmodule

// ==== dv/reader_status_led_control_asserts.sv ====
// Purpose: port checks for the lamp controller
// Assumes: runs stay inside self-test
// Notes: bound to every instance
`timescale 1ns/100ps
module reader_status_led_control_asserts
  import status_lamp_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire sys_status_t sysStatus,
  input wire logic [3:0]  portBusy,
  input wire logic [3:0]  portSense,
  input wire logic [3:0]  digIn,
  input wire logic [3:0]  digOut,
  input wire lamps_t      lamps,
  input wire logic [3:0]  portEnable,
  input wire logic        ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_supply_on: assert property ((!rst)[*3] |-> lamps.supplyIndicator)
    else $error("supply lamp dark");
  a_input_mirror: assert property ((!rst)[*4] |-> lamps.inputIndicator == $past(digIn, 3))
    else $error("input lamps differ");
  a_output_mirror: assert property ((!rst)[*4] |-> lamps.outputIndicator == $past(digOut, 3))
    else $error("output lamps differ");
  a_ok_lamp: assert property ((sysStatus.cmdOk && !sysStatus.cmdFail) ##1 !sysStatus.cmdFail
    |=> lamps.normalIndicator && !lamps.failureIndicator) else $error("normal lamp late");
  a_fail_lamp: assert property (sysStatus.cmdFail ##1 !sysStatus.cmdOk
    |=> lamps.failureIndicator && !lamps.normalIndicator) else $error("failure lamp late");
  a_halt_error: assert property (sysStatus.sysError[*3] |=> lamps.errorIndicator && !lamps.runIndicator)
    else $error("halt not shown");
  a_error_idle: assert property ((!sysStatus.sysError && !sysStatus.setError && !sysStatus.netWait)[*3]
    |=> !lamps.errorIndicator) else $error("error lamp without cause");
  a_port_disabled: assert property (!ready |-> lamps.portActivityIndicator == 4'h0)
    else $error("port lamp during self-test");
endmodule

bind reader_status_led_control reader_status_led_control_asserts u_chk (.clock(clock), .rst(rst),
  .sysStatus(sysStatus), .portBusy(portBusy), .portSense(portSense), .digIn(digIn),
  .digOut(digOut), .lamps(lamps), .portEnable(portEnable), .ready(ready));

// ==== dv/lamp_panel_model.sv ====
// Purpose: operator view of the panel
// Assumes: one clock
// Notes: flags a supply lamp that goes dark once lit
`timescale 1ns/100ps
module lamp_panel_model
  import status_lamp_pkg::*;
(
  // clock and reset
  input  wire logic   clock,
  input  wire logic   rst,
  // lamps
  input  wire lamps_t lamps,
  output logic        supplyDark
);
  logic seenOn_q;
  always_ff @(posedge clock)
  begin
    seenOn_q   <= !rst && (seenOn_q || lamps.supplyIndicator);
    supplyDark <= !rst && (supplyDark || (seenOn_q && !lamps.supplyIndicator));
  end
endmodule

// ==== dv/reader_status_led_control_tb.sv ====
// Purpose: self-checking bench for the lamp controller
// Assumes: self-test is far longer than this run
// Notes: seed fixed at 33
`timescale 1ns/100ps
module reader_status_led_control_tb
  import status_lamp_pkg::*;
;
  logic        clock;
  logic        rst;
  sys_status_t sysStatus;
  logic [3:0]  portBusy, portSense, digIn, digOut, vIn, vOut, portEnable;
  lamps_t      lamps;
  logic        ready, supplyDark;
  logic [1:0]  res;
  int          failures, tests_run;

  reader_status_led_control u_reader_status_led_control (.clock(clock), .rst(rst),
    .sysStatus(sysStatus), .portBusy(portBusy), .portSense(portSense), .digIn(digIn),
    .digOut(digOut), .lamps(lamps), .portEnable(portEnable), .ready(ready));
  lamp_panel_model u_lamp_panel_model (.clock(clock), .rst(rst), .lamps(lamps),
    .supplyDark(supplyDark));

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  function automatic logic exp_error(input sys_status_t s);
    return s.sysError | s.setError | s.netWait;
  endfunction

  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_edges(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic test_done();
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #(25 * 3000);
    failures++;
    test_done();
  end

  initial
  begin
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    sysStatus = '0;
    {portBusy, portSense, digIn, digOut} = 16'h0000;
    void'($urandom(33));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    wait_edges(3);
    check("supply", lamps.supplyIndicator, 1'b1);
    check("ready", ready, 1'b0);
    // first two passes pin the all-on and all-off corners
    for (int i = 0; i < 20; i++)
    begin
      vIn = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($urandom);
      vOut = ~vIn;
      if (i > 1) vOut = 4'($urandom);
      @(posedge clock);
      digIn <= vIn;
      digOut <= vOut;
      portBusy <= 4'($urandom);
      portSense <= 4'($urandom);
      wait_edges(3);
      check("inputs", lamps.inputIndicator, vIn);
      check("outputs", lamps.outputIndicator, vOut);
      check("port lamps", lamps.portActivityIndicator, 4'h0);
      check("port enable", portEnable, 4'h0);
    end
    // ok, fail cuts ok, both at once, ok cuts fail
    for (int i = 0; i < 4; i++)
    begin
      res = (i == 1) ? 2'b01 : (i == 2) ? 2'b11 : 2'b10;
      @(posedge clock);
      {sysStatus.cmdOk, sysStatus.cmdFail} <= res;
      @(posedge clock);
      {sysStatus.cmdOk, sysStatus.cmdFail} <= 2'b00;
      wait_edges(1);
      check("normal", lamps.normalIndicator, res == 2'b10);
      check("failure", lamps.failureIndicator, res[0]);
    end
    // booting, safe mode, halt, settings error, network wait, none
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clock);
      sysStatus <= sys_status_t'((i < 5) ? (7'h40 >> i) : 7'h00);
      wait_edges(4);
      check("error lamp", lamps.errorIndicator, exp_error(sysStatus));
      check("run lamp", lamps.runIndicator, !sysStatus.sysError);
    end
    check("supply dark", supplyDark, 1'b0);
    test_done();
  end
endmodule
